// >>> hw/rtc_pkg.sv
package rtc_pkg;
	// ==========================================
	// clocking
	localparam int CLK_HZ = 20000000;
	localparam int OSC_HZ = 32768;
	localparam int ACC_W = 25;
	localparam int DIV_W = 15;
	localparam logic [DIV_W-1:0] TAP_4096 = 15'h0007;
	localparam logic [DIV_W-1:0] TAP_64 = 15'h01FF;
	localparam logic [DIV_W-1:0] TAP_1HZ = 15'h7FFF;

	// ==========================================
	// register map
	localparam logic [7:0] ADDR_CS_ONE = 8'h00;
	localparam logic [7:0] ADDR_CS_TWO = 8'h01;
	localparam logic [7:0] ADDR_VAL_SEC = 8'h02;

	localparam int CS1_EXT_TEST = 7;
	localparam int CS1_STOP = 5;
	localparam int CS1_RST_OVR = 3;
	localparam logic [7:0] CS1_MASK = 8'hA8;
	localparam logic [7:0] CS1_RST = 8'h00;

	localparam int CS2_PULSE = 4;
	localparam int CS2_AF = 3;
	localparam int CS2_TF = 2;
	localparam int CS2_AIE = 1;
	localparam int CS2_TIE = 0;
	localparam logic [7:0] CS2_MASK = 8'h1F;
	localparam logic [7:0] CS2_RST = 8'h00;

	localparam int SEC_VL = 7;
	localparam logic [7:0] SEC_RST = 8'h80;
	localparam logic [6:0] SEC_MAX = 7'h59;
	localparam logic [3:0] BCD_NINE = 4'h9;

	// ==========================================
	// interrupt pulse widths, as reciprocal seconds
	localparam int PW_SHORT_4096_HZ = 8192;
	localparam int PW_LONG_4096_HZ = 4096;
	localparam int PW_SHORT_64_HZ = 128;
	localparam int PW_LONG_64_HZ = 64;
	localparam int PW_SHORT_4096 = CLK_HZ / PW_SHORT_4096_HZ;
	localparam int PW_W = 19;
	localparam logic [7:0] COUNT_ONE = 8'h01;

	typedef enum logic [1:0] {
		SRC_4096,
		SRC_64,
		SRC_1HZ,
		SRC_SIXTIETH
	} rtc_tsrc_t;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} rtc_wr_t;
endpackage

// >>> hw/rtc_prescaler.sv
`timescale 1ns/10ps
module rtc_prescaler (
	input wire logic i_clk, // system clock
	input wire logic i_rst, // sync reset
	input wire logic i_stop, // clear and hold chain
	input wire logic i_test_sel, // step chain from test clock
	input wire logic i_test_clk, // test step enable
	output logic o_tick_osc, // 32.768 kHz enable
	output logic o_tick_4096, // 4096 Hz enable
	output logic o_tick_64, // 64 Hz enable
	output logic o_tick_1hz // 1 Hz enable
);
	// ==========================================
	// fractional oscillator from system clock
	logic [rtc_pkg::ACC_W-1:0] acc_r;
	logic [rtc_pkg::ACC_W:0] acc_sum;
	wire osc_wrap = acc_sum >= (rtc_pkg::ACC_W+1)'(rtc_pkg::CLK_HZ);
	assign acc_sum = {1'b0, acc_r} + (rtc_pkg::ACC_W+1)'(rtc_pkg::OSC_HZ);

	// ==========================================
	// divider chain
	logic [rtc_pkg::DIV_W-1:0] chain_r;
	wire step = i_test_sel ? i_test_clk : osc_wrap;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			acc_r <= '0;
			o_tick_osc <= 1'b0;
		end else begin
			acc_r <= osc_wrap ? rtc_pkg::ACC_W'(acc_sum - (rtc_pkg::ACC_W+1)'(rtc_pkg::CLK_HZ))
				: rtc_pkg::ACC_W'(acc_sum);
			o_tick_osc <= osc_wrap;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || i_stop) begin // see (R1)
			chain_r <= '0;
			o_tick_4096 <= 1'b0;
			o_tick_64 <= 1'b0;
			o_tick_1hz <= 1'b0;
		end else begin
			chain_r <= step ? chain_r + 15'h0001 : chain_r;
			o_tick_4096 <= step && ((chain_r & rtc_pkg::TAP_4096) == rtc_pkg::TAP_4096);
			o_tick_64 <= step && ((chain_r & rtc_pkg::TAP_64) == rtc_pkg::TAP_64);
			o_tick_1hz <= step && (chain_r == rtc_pkg::TAP_1HZ);
		end
	end
endmodule // rtc_prescaler

// >>> hw/rtc_ctrl_status.sv
// Overview of operation
// (R1) Stop bit clears the divider chain and halts timekeeping; oscillator tick stays.
// (R2) Control bit 3 allows reset override; zero keeps it off.
// (R3) Unused bits of both control registers read zero.
// (R4) Alarm event sets alarm flag; timer completion sets timer flag.
// (R5) Flags hold until software writes them.
// (R6) Writes AND flag bits with written data; zero clears, one keeps.
// (R7) Each enable gates its flag; interrupt is OR of both.
// (R8) Level mode: interrupt follows timer flag when timer enable set.
// (R9) Pulse mode: timer interrupt pulses; enabled alarm flag holds interrupt active.
// (R10) Pulse width chosen by timer source clock and count of one.
// (R11) Timer flag and interrupt go active in the same cycle.
// (R12) Loaded count of zero produces no timer events.
// (R13) Seconds bit 7 flags that time data may be invalid.
// (R14) Seconds bits 6 to 0 hold BCD 00 to 59.
// (R15) Alarm flag sets only when time newly increments into a match.
// (R16) Seconds advance on each 1 Hz tick, wrap 59 to 00, carry out.
`timescale 1ns/10ps
module rtc_ctrl_status #(
	parameter int PW_LONG_4096 = rtc_pkg::CLK_HZ / rtc_pkg::PW_LONG_4096_HZ,
	parameter int PW_SHORT_64 = rtc_pkg::CLK_HZ / rtc_pkg::PW_SHORT_64_HZ,
	parameter int PW_LONG_64 = rtc_pkg::CLK_HZ / rtc_pkg::PW_LONG_64_HZ
) (
	input wire logic I_CLK, // 20 MHz clock
	input wire logic I_SYS_RST, // sync reset, active high
	input wire rtc_pkg::rtc_wr_t I_REG_WR, // register write strobe, address, data
	input wire logic [7:0] I_REG_RD_ADDR, // register read address
	output logic [7:0] O_REG_RDATA, // read data, one cycle later
	input wire logic I_ALARM_MATCH, // alarm comparators all match
	input wire logic I_TIMER_DONE, // countdown reached end, pulse
	input wire rtc_pkg::rtc_tsrc_t I_TIMER_SRC, // timer source clock select
	input wire logic [7:0] I_TIMER_COUNT, // loaded countdown value
	input wire logic I_VOLTAGE_LOW, // supply too low, level
	input wire logic I_EXT_TEST_CLK, // external test clock step
	output logic O_RST_OVERRIDE_ALLOW, // reset override permitted
	output logic O_CLOCK_OUTPUT_PIN_TICK, // 32.768 kHz enable
	output logic O_TICK_4096, // 4096 Hz enable
	output logic O_TICK_64, // 64 Hz enable
	output logic O_TICK_1HZ, // 1 Hz enable
	output logic O_MIN_CARRY, // seconds wrapped, pulse
	input wire logic I_INT_PIN, // interrupt pin level
	output logic O_INT_OUT, // interrupt pin drive value
	output logic O_INT_OE_N, // interrupt pin enable, low drives
	output logic O_IRQ // interrupt asserted, active high
);
	// ==========================================
	// registers
	logic [7:0] cs_one_r;
	logic [7:0] cs_two_r;
	logic vl_r;
	logic [6:0] sec_r;
	logic match_d_r;
	logic [rtc_pkg::PW_W-1:0] pulse_cnt_r;
	logic [7:0] rdata_r;
	logic carry_r;

	wire wr_cs1 = I_REG_WR.en && (I_REG_WR.addr == rtc_pkg::ADDR_CS_ONE);
	wire wr_cs2 = I_REG_WR.en && (I_REG_WR.addr == rtc_pkg::ADDR_CS_TWO);
	wire wr_sec = I_REG_WR.en && (I_REG_WR.addr == rtc_pkg::ADDR_VAL_SEC);

	wire stop = cs_one_r[rtc_pkg::CS1_STOP];
	wire pulse_mode = cs_two_r[rtc_pkg::CS2_PULSE];
	wire af = cs_two_r[rtc_pkg::CS2_AF];
	wire tf = cs_two_r[rtc_pkg::CS2_TF];
	wire alarm_irq_enable = cs_two_r[rtc_pkg::CS2_AIE];
	wire timer_irq_enable = cs_two_r[rtc_pkg::CS2_TIE];

	// ==========================================
	// prescaler
	logic tick_1hz;
	rtc_prescaler u_prescaler (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.i_stop(stop),
		.i_test_sel(cs_one_r[rtc_pkg::CS1_EXT_TEST]),
		.i_test_clk(I_EXT_TEST_CLK),
		.o_tick_osc(O_CLOCK_OUTPUT_PIN_TICK),
		.o_tick_4096(O_TICK_4096),
		.o_tick_64(O_TICK_64),
		.o_tick_1hz(tick_1hz)
	);
	assign O_TICK_1HZ = tick_1hz;

	// ==========================================
	// flag events
	wire af_set = I_ALARM_MATCH && !match_d_r; // see (R15) (R4)
	wire tf_set = I_TIMER_DONE && (I_TIMER_COUNT != 8'h00); // see (R12) (R4)
	wire af_keep = !wr_cs2 || I_REG_WR.data[rtc_pkg::CS2_AF]; // see (R6)
	wire tf_keep = !wr_cs2 || I_REG_WR.data[rtc_pkg::CS2_TF]; // see (R6)

	logic [7:0] cs_two_nxt;
	always_comb begin
		cs_two_nxt = wr_cs2 ? (I_REG_WR.data & rtc_pkg::CS2_MASK) : cs_two_r; // see (R3)
		cs_two_nxt[rtc_pkg::CS2_AF] = af_set || (af && af_keep); // see (R5) (R6)
		cs_two_nxt[rtc_pkg::CS2_TF] = tf_set || (tf && tf_keep); // see (R5) (R6)
	end

	// ==========================================
	// pulse width select
	wire count_one = I_TIMER_COUNT == rtc_pkg::COUNT_ONE;
	logic [rtc_pkg::PW_W-1:0] width_sel;
	always_comb begin
		unique case (I_TIMER_SRC) // see (R10)
			rtc_pkg::SRC_4096: width_sel = count_one ? rtc_pkg::PW_W'(rtc_pkg::PW_SHORT_4096)
				: rtc_pkg::PW_W'(PW_LONG_4096);
			rtc_pkg::SRC_64: width_sel = count_one ? rtc_pkg::PW_W'(PW_SHORT_64) : rtc_pkg::PW_W'(PW_LONG_64);
			rtc_pkg::SRC_1HZ: width_sel = rtc_pkg::PW_W'(PW_LONG_64);
			rtc_pkg::SRC_SIXTIETH: width_sel = rtc_pkg::PW_W'(PW_LONG_64);
		endcase
	end
	wire pulse_active = pulse_cnt_r != '0;

	// ==========================================
	// interrupt
	wire timer_irq = timer_irq_enable && (pulse_mode ? pulse_active : tf); // see (R8) (R9)
	wire alarm_irq = alarm_irq_enable && af; // see (R7) (R9)
	assign O_IRQ = timer_irq || alarm_irq; // see (R7) (R11)
	assign O_INT_OUT = 1'b0;
	assign O_INT_OE_N = !O_IRQ;

	// ==========================================
	// seconds counter
	logic [6:0] sec_inc;
	wire sec_wrap = sec_r == rtc_pkg::SEC_MAX;
	always_comb begin
		if (sec_wrap) begin // see (R16)
			sec_inc = 7'h00;
		end else if (sec_r[3:0] == rtc_pkg::BCD_NINE) begin
			sec_inc = {sec_r[6:4] + 3'h1, 4'h0};
		end else begin
			sec_inc = {sec_r[6:4], sec_r[3:0] + 4'h1};
		end
	end
	wire [6:0] sec_nxt = wr_sec ? I_REG_WR.data[6:0] : (tick_1hz ? sec_inc : sec_r); // see (R14)
	wire vl_nxt = I_VOLTAGE_LOW || (wr_sec ? I_REG_WR.data[rtc_pkg::SEC_VL] : vl_r); // see (R13)

	logic [7:0] rd_mux;
	always_comb begin
		unique case (I_REG_RD_ADDR)
			rtc_pkg::ADDR_CS_ONE: rd_mux = cs_one_r & rtc_pkg::CS1_MASK; // see (R3)
			rtc_pkg::ADDR_CS_TWO: rd_mux = cs_two_r & rtc_pkg::CS2_MASK; // see (R3)
			rtc_pkg::ADDR_VAL_SEC: rd_mux = {vl_r, sec_r};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			cs_one_r <= rtc_pkg::CS1_RST;
			cs_two_r <= rtc_pkg::CS2_RST;
			{vl_r, sec_r} <= rtc_pkg::SEC_RST;
			match_d_r <= 1'b1;
			pulse_cnt_r <= '0;
			rdata_r <= 8'h00;
			carry_r <= 1'b0;
		end else begin
			if (wr_cs1) begin
				cs_one_r <= I_REG_WR.data & rtc_pkg::CS1_MASK; // see (R1) (R2)
			end
			cs_two_r <= cs_two_nxt;
			vl_r <= vl_nxt;
			sec_r <= sec_nxt;
			match_d_r <= I_ALARM_MATCH;
			pulse_cnt_r <= tf_set ? width_sel : (pulse_active ? pulse_cnt_r - 1'b1 : pulse_cnt_r); // see (R10)
			rdata_r <= rd_mux;
			carry_r <= tick_1hz && !wr_sec && sec_wrap; // see (R16)
		end
	end
	assign O_REG_RDATA = rdata_r;
	assign O_MIN_CARRY = carry_r;
	assign O_RST_OVERRIDE_ALLOW = cs_one_r[rtc_pkg::CS1_RST_OVR]; // see (R2)

	// ==========================================
	// assertions
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	sequence s_timer_evt;
		tf_set && timer_irq_enable;
	endsequence
	sequence s_flag_and_int;
		tf && O_IRQ;
	endsequence

	a_stop_halts: assert property (stop |=> !tick_1hz) else $error("1 Hz tick while stopped"); // see (R1)
	a_ovr_follows: assert property (wr_cs1 |=> O_RST_OVERRIDE_ALLOW == $past(I_REG_WR.data[3]))
		else $error("override allow not written"); // see (R2)
	a_cs_reserved_zero: assert property ((I_REG_RD_ADDR == rtc_pkg::ADDR_CS_TWO) |=> O_REG_RDATA[7:5] == 3'h0)
		else $error("reserved bits not zero"); // see (R3)
	a_alarm_sets: assert property (af_set |=> af) else $error("alarm flag not set"); // see (R4)
	a_flag_holds: assert property (tf && !wr_cs2 |=> tf) else $error("timer flag lost"); // see (R5)
	a_and_clear: assert property (wr_cs2 && !I_REG_WR.data[3] && !af_set |=> !af)
		else $error("alarm flag not cleared"); // see (R6)
	a_alarm_irq: assert property (af && alarm_irq_enable |-> O_IRQ && !O_INT_OE_N) else $error("alarm irq missing"); // see (R7)
	a_level_irq: assert property (!pulse_mode && timer_irq_enable && tf |-> O_IRQ) else $error("level irq missing"); // see (R8)
	a_pulse_only: assert property (pulse_mode && !pulse_active && !alarm_irq |-> !O_IRQ)
		else $error("irq outside pulse"); // see (R9)
	a_pulse_width: assert property (tf_set |=> pulse_cnt_r == $past(width_sel))
		else $error("pulse width wrong"); // see (R10)
	a_same_cycle: assert property (s_timer_evt |=> s_flag_and_int) else $error("flag and irq split"); // see (R11)
	a_zero_count: assert property (I_TIMER_DONE && I_TIMER_COUNT == 8'h00 && !tf |=> !tf)
		else $error("timer event at zero count"); // see (R12)
	a_vl_sets: assert property (I_VOLTAGE_LOW |=> vl_r)
		else $error("validity flag not set"); // see (R13)
	a_sec_wrap: assert property (tick_1hz && sec_wrap && !wr_sec |=> sec_r == 7'h00 && O_MIN_CARRY)
		else $error("seconds wrap wrong"); // see (R14) (R16)
	a_rearm: assert property (I_ALARM_MATCH && match_d_r |-> !af_set) else $error("alarm retriggered"); // see (R15)
endmodule // rtc_ctrl_status

// >>> bench/rtc_host.sv
`timescale 1ns/10ps
module rtc_host (
	input wire logic i_clk, // system clock
	output rtc_pkg::rtc_wr_t o_wr, // register write
	output logic [7:0] o_rd_addr, // read address
	input wire logic [7:0] i_rdata // read data
);
	initial begin
		o_wr = '0;
		o_rd_addr = 8'h00;
	end
	// ==========================================
	// byte access, strobe dropped before the next write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		o_wr = '{en: 1'b1, addr: a, data: d};
		@(posedge i_clk);
		#1;
		o_wr.en = 1'b0;
		@(posedge i_clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		o_rd_addr = a;
		@(posedge i_clk);
		#1;
		d = i_rdata;
	endtask
endmodule // rtc_host

// >>> bench/rtc_ctrl_status_test.sv
`timescale 1ns/10ps
module rtc_ctrl_status_test;
	logic I_CLK, I_SYS_RST, I_ALARM_MATCH, I_TIMER_DONE, I_VOLTAGE_LOW, I_EXT_TEST_CLK, I_INT_PIN;
	logic O_RST_OVERRIDE_ALLOW, O_CLOCK_OUTPUT_PIN_TICK, O_TICK_4096, O_TICK_64, O_TICK_1HZ, O_MIN_CARRY;
	logic O_INT_OUT, O_INT_OE_N, O_IRQ;
	logic [7:0] I_REG_RD_ADDR, O_REG_RDATA, I_TIMER_COUNT, rv;
	rtc_pkg::rtc_wr_t I_REG_WR;
	rtc_pkg::rtc_tsrc_t I_TIMER_SRC;
	int bad_count = 0, checks = 0, seed = 32'hb389, w, n, a, b;
	// pulled up while released
	assign I_INT_PIN = O_INT_OE_N ? 1'b1 : O_INT_OUT;
	initial begin
		I_CLK = 1'b0;
		forever #25 I_CLK = ~I_CLK;
	end
	rtc_host rtc_host_inst (.i_clk(I_CLK), .o_wr(I_REG_WR), .o_rd_addr(I_REG_RD_ADDR), .i_rdata(O_REG_RDATA));
	rtc_ctrl_status #(.PW_LONG_4096(20), .PW_SHORT_64(10), .PW_LONG_64(20)) rtc_ctrl_status_inst (
		.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_REG_WR(I_REG_WR), .I_REG_RD_ADDR(I_REG_RD_ADDR),
		.O_REG_RDATA(O_REG_RDATA), .I_ALARM_MATCH(I_ALARM_MATCH), .I_TIMER_DONE(I_TIMER_DONE),
		.I_TIMER_SRC(I_TIMER_SRC), .I_TIMER_COUNT(I_TIMER_COUNT), .I_VOLTAGE_LOW(I_VOLTAGE_LOW),
		.I_EXT_TEST_CLK(I_EXT_TEST_CLK), .O_RST_OVERRIDE_ALLOW(O_RST_OVERRIDE_ALLOW),
		.O_CLOCK_OUTPUT_PIN_TICK(O_CLOCK_OUTPUT_PIN_TICK), .O_TICK_4096(O_TICK_4096), .O_TICK_64(O_TICK_64),
		.O_TICK_1HZ(O_TICK_1HZ), .O_MIN_CARRY(O_MIN_CARRY), .I_INT_PIN(I_INT_PIN),
		.O_INT_OUT(O_INT_OUT), .O_INT_OE_N(O_INT_OE_N), .O_IRQ(O_IRQ));
	// ==========================================
	// helpers
	function automatic int exp_width(input int s, input int cnt);
		if (s == 0) return (cnt == 1) ? rtc_pkg::PW_SHORT_4096 : 20;
		return (s == 1 && cnt == 1) ? 10 : 20;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge I_CLK);
		#1;
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
		rtc_host_inst.rd(ad, rv);
		chk(rv, e);
	endtask
	task automatic tdone(input int s, input logic [7:0] cnt);
		I_TIMER_SRC = rtc_pkg::rtc_tsrc_t'(s);
		I_TIMER_COUNT = cnt;
		I_TIMER_DONE = 1'b1;
		step(1);
		I_TIMER_DONE = 1'b0;
	endtask
	// ==========================================
	// main sequence
	initial begin
		{I_SYS_RST, I_ALARM_MATCH, I_TIMER_DONE, I_VOLTAGE_LOW, I_EXT_TEST_CLK} = 5'h10;
		I_TIMER_SRC = rtc_pkg::SRC_1HZ;
		I_TIMER_COUNT = 8'h05;
		step(16);
		I_SYS_RST = 1'b0;
		rchk(8'h00, 8'h00);
		rchk(8'h01, 8'h00);
		rchk(8'h02, 8'h80);
		rchk(8'h03, 8'h00);
		$display("reset test done");
		rtc_host_inst.wr(8'h01, 8'h01);
		tdone(2, 8'h05);
		chk(O_IRQ, 1'h1);
		chk(O_INT_OE_N, 1'h0);
		step(10);
		rchk(8'h01, 8'h05);
		rtc_host_inst.wr(8'h01, 8'h01);
		chk(O_IRQ, 1'h0);
		tdone(2, 8'h00);
		rchk(8'h01, 8'h01);
		$display("level timer test done");
		rtc_host_inst.wr(8'h01, 8'h03);
		I_ALARM_MATCH = 1'b1;
		step(1);
		rchk(8'h01, 8'h0B);
		chk(O_IRQ, 1'h1);
		tdone(2, 8'h03);
		rchk(8'h01, 8'h0F);
		rtc_host_inst.wr(8'h01, 8'h0B);
		rchk(8'h01, 8'h0B);
		rtc_host_inst.wr(8'h01, 8'h07);
		step(20);
		rchk(8'h01, 8'h03);
		rtc_host_inst.wr(8'h01, 8'h03);
		chk(O_IRQ, 1'h0);
		I_ALARM_MATCH = 1'b0;
		$display("alarm test done");
		rtc_host_inst.wr(8'h01, 8'h11);
		for (a = 0; a < 4; a++) begin
			for (b = 0; b < 2; b++) begin
				n = b ? 2 + ($unsigned($random(seed)) % 254) : 1;
				tdone(a, n[7:0]);
				w = 0;
				while (O_IRQ === 1'b1 && w < 3000) begin
					w++;
					step(1);
				end
				chk(w, exp_width(a, n));
				if (w >= 3000) close_out();
			end
		end
		rtc_host_inst.wr(8'h01, 8'h13);
		I_ALARM_MATCH = 1'b1;
		step(40);
		chk(O_IRQ, 1'h1);
		I_ALARM_MATCH = 1'b0;
		rtc_host_inst.wr(8'h01, 8'h00);
		$display("pulse test done");
		rtc_host_inst.wr(8'h00, 8'hFF);
		rchk(8'h00, 8'hA8);
		chk(O_RST_OVERRIDE_ALLOW, 1'h1);
		a = 0;
		b = 0;
		repeat (2000) begin
			step(1);
			a += O_CLOCK_OUTPUT_PIN_TICK;
			b += O_TICK_4096;
		end
		chk(b, 0);
		chk(a > 0, 1'h1);
		$display("stop test done");
		rtc_host_inst.wr(8'h00, 8'h80);
		I_EXT_TEST_CLK = 1'b1;
		rtc_host_inst.wr(8'h02, 8'h59);
		rchk(8'h02, 8'h59);
		w = 0;
		while (O_MIN_CARRY !== 1'b1 && w < 40000) begin
			w++;
			step(1);
		end
		chk(O_MIN_CARRY, 1'h1);
		if (w >= 40000) close_out();
		rchk(8'h02, 8'h00);
		I_VOLTAGE_LOW = 1'b1;
		step(1);
		I_VOLTAGE_LOW = 1'b0;
		rchk(8'h02, 8'h80);
		// software returns override to off
		rtc_host_inst.wr(8'h00, 8'h00);
		chk(O_RST_OVERRIDE_ALLOW, 1'h0);
		$display("seconds test done");
		close_out();
	end
endmodule // rtc_ctrl_status_test
